// ---- hdl/ram_agen_defs.vh ----
// Constants for the data RAM address generator.
// Included by every design file of the block; definitions only.
`ifndef RAM_AGEN_DEFS_VH
`define RAM_AGEN_DEFS_VH

// Pointer field layout
`define FLD_SEL_LSB      0
`define FLD_SEL_MSB      1
`define FLD_MOD_LSB      2
`define FLD_MOD_MSB      3
`define SEL_SHORT_DIRECT 2'h3
`define MOD_NONE         2'h0
`define MOD_INC          2'h1
`define MOD_DEC_LOOP     2'h2
`define MOD_INC_LOOP     2'h3

// Instruction bank bit
`define INSTR_BANK_BIT   8

// Status word fields
`define SR_LOOP_LSB      0
`define SR_LOOP_MSB      2
`define SR_PAGE_LSB      3
`define SR_PAGE_MSB      4

// Direct address bank bit (256..511 is bank 1)
`define DIRECT_BANK_BIT  8

// Access kinds
`define OP_IDLE          3'h0
`define OP_REGIND        3'h1
`define OP_DIRECT        3'h2
`define OP_MEMIND        3'h3
`define OP_ACCIND        3'h4
`define OP_SIMM          3'h5
`define OP_LIMM          3'h6

// Accumulator bits used as program address
`define ACC_ADDR_LSB     8
`define ACC_ADDR_MSB     23

// Reset values
`define PTR_RESET        8'h00
`define PM_RESET         16'h0000

// Memory-indirect sequencing
`define MI_IDLE          4'h1
`define MI_FETCH         4'h2
`define MI_READ          4'h4
`define MI_WRITE         4'h8

`endif

// ---- hdl/loop_pointer_update.v ----
// Next value of one ram pointer under the coded update.
// Purely combinational; the caller stores the result.
`include "ram_agen_defs.vh"

module loop_pointer_update (
	ptr_in,
	mod_code,
	loop_size_field,
	ptr_out
);
	input  wire [7:0] ptr_in;
	input  wire [1:0] mod_code;
	input  wire [2:0] loop_size_field;
	output reg  [7:0] ptr_out;

	reg [7:0] wrap_mask;
	reg [7:0] stepped;

	always @* begin
		// Code 000 means 256: the whole pointer wraps
		wrap_mask = (loop_size_field == 3'h0) ? 8'hff : ((8'h01 << loop_size_field) - 8'h01);
		stepped   = 8'h00;
		ptr_out   = ptr_in;
		case (mod_code)
			`MOD_NONE: begin
				ptr_out = ptr_in;
			end
			`MOD_INC: begin
				ptr_out = ptr_in + 8'h01;
			end
			`MOD_DEC_LOOP: begin
				stepped = ptr_in - 8'h01;
				ptr_out = (ptr_in & ~wrap_mask) | (stepped & wrap_mask);
			end
			`MOD_INC_LOOP: begin
				stepped = ptr_in + 8'h01;
				ptr_out = (ptr_in & ~wrap_mask) | (stepped & wrap_mask);
			end
			default: begin
				ptr_out = ptr_in;
			end
		endcase
	end
endmodule // loop_pointer_update

// ---- hdl/ram_addr_decode.v ----
// Decodes a pointer field into pointer index or short-form address.
// Combinational; inputs come from the instruction decoder.
`include "ram_agen_defs.vh"

module ram_addr_decode (
	ptr_field,
	bank_bit,
	page_bits,
	use_short,
	ptr_index,
	short_addr
);
	input  wire [3:0] ptr_field;
	input  wire       bank_bit;
	input  wire [1:0] page_bits;
	output wire       use_short;
	output wire [2:0] ptr_index;
	output wire [8:0] short_addr;

	wire [1:0] sel;
	assign sel        = ptr_field[`FLD_SEL_MSB:`FLD_SEL_LSB];
	assign use_short  = (sel == `SEL_SHORT_DIRECT);
	// Bank bit picks the upper pointer set
	assign ptr_index  = {1'b0, sel} + (bank_bit ? 3'h3 : 3'h0);
	// Bank bit on top, then page bits over field upper bits: lowest sixteen words of each bank only
	assign short_addr = {bank_bit, 4'h0, page_bits, ptr_field[`FLD_MOD_MSB:`FLD_MOD_LSB]};
endmodule // ram_addr_decode

// ---- hdl/data_ram_address_generator.v ----
// Data RAM and program-memory data address generator.
// Assumes the decoder holds op inputs for one cycle per request and
// that the RAM returns read data in the same cycle as ram_rd_ff.
`include "ram_agen_defs.vh"

module data_ram_address_generator (
	core_clk,
	rst_b,
	op_valid,
	op_kind,
	op_write,
	instr_word,
	operand_word,
	status_word,
	acc_value,
	ram_rd_data,
	busy_ff,
	ram_addr_ff,
	ram_rd_ff,
	ram_wr_ff,
	ram_wr_data_ff,
	acc_xfer_ff,
	pm_addr_ff,
	pm_rd_ff,
	ptr_flat_ff
);
	input  wire        core_clk;
	input  wire        rst_b;
	input  wire        op_valid;
	input  wire [2:0]  op_kind;
	input  wire        op_write;
	input  wire [15:0] instr_word;
	input  wire [15:0] operand_word;
	input  wire [15:0] status_word;
	input  wire [23:0] acc_value;
	input  wire [15:0] ram_rd_data;
	output reg         busy_ff;
	output reg  [8:0]  ram_addr_ff;
	output reg         ram_rd_ff;
	output reg         ram_wr_ff;
	output reg  [15:0] ram_wr_data_ff;
	output reg         acc_xfer_ff;
	output reg  [15:0] pm_addr_ff;
	output reg         pm_rd_ff;
	output reg  [47:0] ptr_flat_ff;

	// Six pointers, index 0..2 bank 0, 3..5 bank 1
	reg  [7:0] ram_pointer_ff [0:5];
	reg  [7:0] nxt_ram_pointer [0:5];
	reg  [3:0] mi_state_ff;
	reg  [3:0] nxt_mi_state;
	reg  [8:0] mi_addr_ff;
	reg  [8:0] nxt_mi_addr;

	wire [3:0] ptr_field;
	wire       bank_bit;
	wire       use_short;
	wire [2:0] ptr_index;
	wire [8:0] short_addr;
	wire [7:0] cur_ptr;
	wire [7:0] upd_ptr;
	wire [8:0] ind_addr;
	wire [2:0] simm_index;
	wire       take;

	assign ptr_field  = instr_word[3:0];
	assign bank_bit   = instr_word[`INSTR_BANK_BIT];
	// Short immediate names its pointer in bits 10:9 of the word
	assign simm_index = {1'b0, instr_word[10:9]} + (bank_bit ? 3'h3 : 3'h0);
	assign take       = op_valid && !busy_ff;

	ram_addr_decode u_decode (
		.ptr_field  (ptr_field),
		.bank_bit   (bank_bit),
		.page_bits  (status_word[`SR_PAGE_MSB:`SR_PAGE_LSB]),
		.use_short  (use_short),
		.ptr_index  (ptr_index),
		.short_addr (short_addr)
	);

	assign cur_ptr = ram_pointer_ff[ptr_index];

	loop_pointer_update u_update (
		.ptr_in          (cur_ptr),
		.mod_code        (ptr_field[`FLD_MOD_MSB:`FLD_MOD_LSB]),
		.loop_size_field (status_word[`SR_LOOP_MSB:`SR_LOOP_LSB]),
		.ptr_out         (upd_ptr)
	);

	// Pointer value addresses its own bank's word
	assign ind_addr = use_short ? short_addr : {bank_bit, cur_ptr};

	integer i;

	always @* begin
		for (i = 0; i < 6; i = i + 1) begin
			nxt_ram_pointer[i] = ram_pointer_ff[i];
		end
		nxt_mi_state = mi_state_ff;
		nxt_mi_addr  = mi_addr_ff;
		case (mi_state_ff)
			`MI_IDLE: begin
				if (take) begin
					if ((op_kind == `OP_REGIND || op_kind == `OP_MEMIND) && !use_short) begin
						nxt_ram_pointer[ptr_index] = upd_ptr;
					end
					if (op_kind == `OP_SIMM) begin
						nxt_ram_pointer[simm_index] = operand_word[7:0];
					end
					if (op_kind == `OP_MEMIND) begin
						nxt_mi_addr  = ind_addr;
						nxt_mi_state = `MI_FETCH;
					end
				end
			end
			`MI_FETCH: begin
				nxt_mi_state = `MI_READ;
			end
			`MI_READ: begin
				nxt_mi_state = `MI_WRITE;
			end
			`MI_WRITE: begin
				nxt_mi_state = `MI_IDLE;
			end
			default: begin
				nxt_mi_state = `MI_IDLE;
			end
		endcase
	end

	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_ptr
			always @(posedge core_clk) begin
				if (!rst_b) begin
					ram_pointer_ff[g] <= `PTR_RESET;
				end else begin
					ram_pointer_ff[g] <= nxt_ram_pointer[g];
				end
			end
		end
	endgenerate

	always @(posedge core_clk) begin
		if (!rst_b) begin
			mi_state_ff    <= `MI_IDLE;
			mi_addr_ff     <= 9'h000;
			busy_ff        <= 1'b0;
			ram_addr_ff    <= 9'h000;
			ram_rd_ff      <= 1'b0;
			ram_wr_ff      <= 1'b0;
			ram_wr_data_ff <= 16'h0000;
			acc_xfer_ff    <= 1'b0;
			pm_addr_ff     <= `PM_RESET;
			pm_rd_ff       <= 1'b0;
		end else begin
			mi_state_ff <= nxt_mi_state;
			mi_addr_ff  <= nxt_mi_addr;
			busy_ff     <= (nxt_mi_state != `MI_IDLE);
			ram_rd_ff   <= 1'b0;
			ram_wr_ff   <= 1'b0;
			acc_xfer_ff <= 1'b0;
			pm_rd_ff    <= 1'b0;
			case (mi_state_ff)
				`MI_IDLE: begin
					if (take) begin
						case (op_kind)
							`OP_REGIND: begin
								ram_addr_ff <= ind_addr;
								ram_rd_ff   <= !op_write;
								ram_wr_ff   <= op_write;
								ram_wr_data_ff <= operand_word;
							end
							`OP_DIRECT: begin
								// Bit 8 of the address is the bank
								ram_addr_ff <= instr_word[8:0];
								ram_rd_ff   <= !op_write;
								ram_wr_ff   <= op_write;
								ram_wr_data_ff <= acc_value[`ACC_ADDR_MSB:`ACC_ADDR_LSB];
								acc_xfer_ff <= 1'b1;
							end
							`OP_MEMIND: begin
								ram_addr_ff <= ind_addr;
								ram_rd_ff   <= 1'b1;
							end
							`OP_ACCIND: begin
								pm_addr_ff <= acc_value[`ACC_ADDR_MSB:`ACC_ADDR_LSB];
								pm_rd_ff   <= 1'b1;
							end
							`OP_LIMM: begin
								// Memory target uses indirect address
								ram_addr_ff    <= ind_addr;
								ram_wr_ff      <= op_write;
								ram_wr_data_ff <= operand_word;
							end
							default: begin
								ram_rd_ff <= 1'b0;
							end
						endcase
					end
				end
				`MI_FETCH: begin
					// RAM word now on ram_rd_data
					pm_addr_ff <= ram_rd_data;
					pm_rd_ff   <= 1'b1;
				end
				`MI_READ: begin
					ram_addr_ff    <= mi_addr_ff;
					ram_wr_ff      <= 1'b1;
					ram_wr_data_ff <= pm_addr_ff + 16'h0001;
				end
				default: begin
					ram_wr_ff <= 1'b0;
				end
			endcase
		end
	end

	// Pointers exported so decode can read them as registers
	always @(posedge core_clk) begin
		if (!rst_b) begin
			ptr_flat_ff <= 48'h000000000000;
		end else begin
			ptr_flat_ff <= {nxt_ram_pointer[5], nxt_ram_pointer[4], nxt_ram_pointer[3],
					nxt_ram_pointer[2], nxt_ram_pointer[1], nxt_ram_pointer[0]};
		end
	end
endmodule // data_ram_address_generator

// ---- verification/data_ram_model.sv ----
// Data RAM at the far side of the address generator, 512 words.
// Read data shows while the read strobe is high and one cycle after.
module data_ram_model (
	input  wire        core_clk,
	input  wire [8:0]  ram_addr_ff,
	input  wire        ram_rd_ff,
	input  wire        ram_wr_ff,
	input  wire [15:0] ram_wr_data_ff,
	output wire [15:0] ram_rd_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [0:511];
	logic [15:0] last_q;
	logic        hold_q;
	initial begin
		for (int i = 0; i < 512; i++)
			mem[i] = 16'h1000 + 16'(i);
		last_q = 16'h0000;
		hold_q = 1'b0;
	end
	// Idle data toggles so a late sample is caught
	assign ram_rd_data = ram_rd_ff ? mem[ram_addr_ff] : hold_q ? last_q : ~last_q;
	always @(posedge core_clk) begin
		hold_q <= ram_rd_ff;
		if (ram_rd_ff)
			last_q <= mem[ram_addr_ff];
		else if (!hold_q)
			last_q <= ~last_q;
		if (ram_wr_ff)
			mem[ram_addr_ff] <= ram_wr_data_ff;
	end
endmodule // data_ram_model

// ---- verification/agen_chk.sv ----
// Port checker for the address generator.
// Bound to the design; one clock, synchronous reset.
module agen_chk (
	input wire        core_clk,
	input wire        rst_b,
	input wire        op_valid,
	input wire [2:0]  op_kind,
	input wire        op_write,
	input wire [15:0] instr_word,
	input wire [15:0] operand_word,
	input wire [15:0] status_word,
	input wire [23:0] acc_value,
	input wire        busy_ff,
	input wire [8:0]  ram_addr_ff,
	input wire        ram_rd_ff,
	input wire        ram_wr_ff,
	input wire [15:0] ram_wr_data_ff,
	input wire        acc_xfer_ff,
	input wire [15:0] pm_addr_ff,
	input wire        pm_rd_ff,
	input wire [47:0] ptr_flat_ff
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	wire       tk  = op_valid && !busy_ff;
	wire [1:0] sel = instr_word[1:0];
	wire [7:0] cur = ptr_flat_ff[(instr_word[8] * 3 + sel) * 8 +: 8];
	sequence mi_take; tk && op_kind == 3'h3; endsequence
	sequence mi_steps; ram_rd_ff ##1 pm_rd_ff ##1 ram_wr_ff && ram_wr_data_ff == pm_addr_ff + 16'h1; endsequence
	memind_order_a: assert property (mi_take |=> mi_steps)
		else $error("memind steps wrong");
	busy_span_a: assert property (mi_take |=> busy_ff [*3] ##1 !busy_ff)
		else $error("busy span wrong");
	direct_addr_a: assert property (tk && op_kind == 3'h2 |=> acc_xfer_ff && ram_addr_ff == $past(instr_word[8:0]))
		else $error("direct address wrong");
	accind_addr_a: assert property (tk && op_kind == 3'h4 |=> pm_rd_ff && pm_addr_ff == $past(acc_value[23:8]))
		else $error("acc address wrong");
	limm_write_a: assert property (tk && op_kind == 3'h6 && op_write |=> ram_wr_ff && ram_wr_data_ff == $past(operand_word))
		else $error("long load wrong");
	simm_only_a: assert property (tk && op_kind == 3'h5 |=> !ram_wr_ff && !ram_rd_ff && !pm_rd_ff)
		else $error("short load touched memory");
	regind_addr_a: assert property (tk && op_kind == 3'h1 && sel != 2'h3 |=> ram_addr_ff == {$past(instr_word[8]), $past(cur)})
		else $error("indirect address wrong");
	short_addr_a: assert property (tk && op_kind == 3'h1 && sel == 2'h3 |=> $stable(ptr_flat_ff) &&
		ram_addr_ff == {$past(instr_word[8]), 4'h0, $past(status_word[4:3]), $past(instr_word[3:2])})
		else $error("short address wrong");
	nop_keep_a: assert property (tk && op_kind == 3'h1 && instr_word[3:2] == 2'h0 |=> $stable(ptr_flat_ff))
		else $error("pointer moved on no-op");
endmodule // agen_chk

bind data_ram_address_generator agen_chk u_chk (.*);

// ---- verification/data_ram_address_generator_test.sv ----
// Self-checking bench for the address generator.
// Uses the RAM model and the bound checker.
module data_ram_address_generator_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk, rst_b, op_valid, op_write;
	logic [2:0]  op_kind;
	logic [15:0] instr_word, operand_word, status_word;
	logic [23:0] acc_value;
	wire  [15:0] ram_rd_data, ram_wr_data_ff, pm_addr_ff;
	wire  [8:0]  ram_addr_ff;
	wire  [47:0] ptr_flat_ff;
	wire         busy_ff, ram_rd_ff, ram_wr_ff, acc_xfer_ff, pm_rd_ff;
	int          bad_count, n_compared;
	logic [7:0]  ep [0:5];

	data_ram_address_generator u_dut (.*);
	data_ram_model u_ram (.*);

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	function automatic logic [47:0] flat(); return {ep[5], ep[4], ep[3], ep[2], ep[1], ep[0]}; endfunction

	function automatic logic [7:0] nxt(input logic [7:0] p, input logic [1:0] m, input logic [2:0] ls);
		logic [7:0] k;
		k = (ls == 3'h0) ? 8'hff : (8'h01 << ls) - 8'h01;
		case (m)
			2'h1: return p + 8'h01;
			2'h2: return (p & ~k) | ((p - 8'h01) & k);
			2'h3: return (p & ~k) | ((p + 8'h01) & k);
			default: return p;
		endcase
	endfunction

	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic results;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic step;
		@(posedge core_clk);
		#1;
	endtask

	// Returns in the cycle after the take, where strobes stand
	task automatic op(input logic [2:0] k, input logic w, input logic [15:0] ins, input logic [15:0] opd);
		step();
		{op_valid, op_kind, op_write, instr_word, operand_word} = {1'b1, k, w, ins, opd};
		step();
		op_valid = 1'b0;
	endtask

	task automatic wait_idle;
		int t = 0;
		while (busy_ff !== 1'b0) begin
			step();
			if (++t > 8) begin
				bad_count++;
				results();
			end
		end
	endtask

	task automatic t_simm;
		for (int i = 0; i < 6; i++) begin
			ep[i] = 8'h3b * 8'(i) + 8'h0f;
			op(3'h5, 1'b0, {5'h00, 2'(i % 3), 1'(i / 3), 8'h00}, {8'hee, ep[i]});
			chk("pointer load", flat(), ptr_flat_ff);
		end
		$display("short load done");
	endtask

	task automatic t_regind;
		logic [3:0] f;
		int         x;
		for (int k = 0; k < 48; k++) begin
			f = {2'(k % 4), 2'(k % 3)};
			x = (k / 24) * 3 + k % 3;
			status_word = {13'h0000, 3'(k % 8)};
			op(3'h1, 1'b0, {7'h00, 1'(k / 24), 4'h0, f}, 16'h0000);
			chk("indirect address", {1'(k / 24), ep[x]}, ram_addr_ff);
			ep[x] = nxt(ep[x], f[3:2], status_word[2:0]);
			chk("pointer update", flat(), ptr_flat_ff);
		end
		op(3'h5, 1'b0, 16'h0100, 16'h00a9);
		status_word = 16'h0005;
		repeat (23) op(3'h1, 1'b0, 16'h010c, 16'h0000);
		chk("loop wrap", 8'ha0, ptr_flat_ff[31:24]);
		ep[3] = 8'ha0;
		// Code 000 loops over all 256 words, so the decrement of pointer 0 uses the whole 8-bit pointer
		status_word = 16'h0000;
		op(3'h1, 1'b0, 16'h0008, 16'h0000);
		ep[0] = ep[0] - 8'h01;
		chk("full loop", flat(), ptr_flat_ff);
		$display("indirect done");
	endtask

	task automatic t_direct;
		logic [8:0] a [3] = '{9'h0ff, 9'h100, 9'h1ff};
		foreach (a[i]) begin
			op(3'h2, 1'(i % 2), {7'h00, a[i]}, 16'h0000);
			chk("direct address", a[i], ram_addr_ff);
			chk("direct to acc", 1'b1, acc_xfer_ff);
		end
		status_word = 16'h0008;
		op(3'h1, 1'b0, 16'h010b, 16'h0000);
		chk("short address", 9'h106, ram_addr_ff);
		chk("short keeps pointers", flat(), ptr_flat_ff);
		$display("direct done");
	endtask

	task automatic t_memind;
		acc_value = 24'h123456;
		for (int n = 0; n < 2; n++) begin
			op(3'h3, 1'b0, 16'h000b, 16'h0000);
			chk("memind read", {1'b1, 9'h006}, {ram_rd_ff, ram_addr_ff});
			step();
			op_valid = 1'b1;
			op_kind = 3'h4;
			chk("memind fetch", {1'b1, 16'h1006 + 16'(n)}, {pm_rd_ff, pm_addr_ff});
			step();
			op_valid = 1'b0;
			chk("memind update", {1'b1, 16'h1007 + 16'(n)}, {ram_wr_ff, ram_wr_data_ff});
			wait_idle();
		end
		chk("busy refuses", 16'h1007, pm_addr_ff);
		$display("memind done");
	endtask

	task automatic t_misc;
		acc_value = 24'hbeef77;
		op(3'h4, 1'b0, 16'h0000, 16'h0000);
		chk("acc program address", {1'b1, 16'hbeef}, {pm_rd_ff, pm_addr_ff});
		op(3'h6, 1'b1, 16'h0001, 16'hc3a5);
		chk("long load", {1'b1, 1'b0, ep[1], 16'hc3a5}, {ram_wr_ff, ram_addr_ff, ram_wr_data_ff});
		$display("immediate done");
	endtask

	initial begin
		rst_b = 1'b0;
		{op_valid, op_kind, op_write, instr_word, operand_word, status_word, acc_value} = '0;
		bad_count = 0;
		n_compared = 0;
		repeat (16) @(posedge core_clk);
		#1;
		rst_b = 1'b1;
		chk("reset pointers", 48'h0, ptr_flat_ff);
		t_simm();
		t_regind();
		t_direct();
		t_memind();
		t_misc();
		results();
	end
endmodule // data_ram_address_generator_test
